// file: src/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
	// =====================================================
	// clock and timing
	localparam int unsigned SYS_CLK_HZ = 25_000_000;
	localparam int unsigned ISCK_FREQ_HZ = 19_200;
	// half period rounds down, so the internal clock never runs slow
	localparam int unsigned ISCK_HALF_CYCLES = SYS_CLK_HZ / (2 * ISCK_FREQ_HZ);
	// longest external oscillator phase is 200 us; twice that means no clock
	localparam int unsigned FSEL_SILENCE_US = 400;
	localparam int unsigned FSEL_SILENCE_CYCLES = (SYS_CLK_HZ / 1_000_000) * FSEL_SILENCE_US;
	// =====================================================
	// conversion and filter
	localparam int unsigned RESULT_BITS = 24;
	localparam int unsigned FILTER_NULL_DIV = 2560;
	localparam int unsigned NULL_F0_HIGH_HZ = 50;
	localparam int unsigned NULL_F0_LOW_HZ = 60;
	// =====================================================
	// synchronised pin vector layout and reset levels
	localparam int unsigned PIN_CS = 0;
	localparam int unsigned PIN_SCK = 1;
	localparam int unsigned PIN_FSEL = 2;
	localparam logic [2:0] PIN_RESET = 3'h3;
	typedef enum logic [2:0] {
		ST_CONV = 3'h1,
		ST_SLEEP = 3'h2,
		ST_DOUT = 3'h4
	} phase_type;
endpackage

// file: src/serial_clk_if.sv
`timescale 1ns/1ps
interface serial_clk_if;
	logic run;
	logic rise;
	logic fall;
	logic level;
	modport gen (input run, output rise, output fall, output level);
	modport ctrl (output run, input rise, input fall, input level);
endinterface

// file: src/sck_gen.sv
`timescale 1ns/1ps
module sck_gen import adc_ctrl_pkg::*; #(
	parameter int unsigned HALF = ISCK_HALF_CYCLES
) (
	// clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// internal serial clock
	serial_clk_if.gen sif
);
	localparam int unsigned CW = $clog2(HALF + 1);
	localparam logic [CW-1:0] LAST = CW'(HALF - 1);
	generate
		if (HALF < 1) begin : g_bad_half
			$error("sck_gen: HALF must be at least 1");
		end
	endgenerate
	logic [CW-1:0] cnt_q, cnt_d;
	logic level_q, level_d, rise_q, rise_d, fall_q, fall_d;
	// =====================================================
	// divider: idles high so the first edge after select is a fall
	always_comb begin
		cnt_d = cnt_q;
		level_d = level_q;
		rise_d = 1'b0;
		fall_d = 1'b0;
		if (!sif.run) begin
			cnt_d = '0;
			level_d = 1'b1;
		end else if (cnt_q == LAST) begin
			cnt_d = '0;
			level_d = ~level_q;
			fall_d = level_q;
			rise_d = ~level_q;
		end else begin
			cnt_d = cnt_q + CW'(1);
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			cnt_q <= '0;
			level_q <= 1'b1;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end else if (i_ce) begin
			cnt_q <= cnt_d;
			level_q <= level_d;
			rise_q <= rise_d;
			fall_q <= fall_d;
		end
	end
	assign sif.level = level_q;
	assign sif.rise = rise_q;
	assign sif.fall = fall_q;
endmodule

// file: src/adc_serial_readout_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - chip select low enables the data output driver and wakes from sleep.
// - after each conversion enter sleep and stay while chip select is high.
// - chip select rising during shifting aborts it and starts a conversion.
// - data output is high impedance while chip select is high.
// - during conversion and sleep the data output shows conversion status.
// - during data output the result bits appear one after another.
// - internal mode drives the serial clock pin; external mode only reads it.
// - internal serial clock mode enables a weak pull-up on the clock pin.
// - clock mode sampled from clock pin at chip select fall; at power-up the high reset level picks internal.
// - frequency select high means internal oscillator with 50 Hz null.
// - frequency select low means internal oscillator with 60 Hz null.
// - a toggling frequency select is the system clock, null at f/2560.
// - output ends after 24 bits or chip select high after the first clock rise, then conversion starts.
// - output bit changes on clock fall; host samples on clock rise.
// - chip select high before first clock rise returns to sleep, result kept.
module adc_serial_readout_ctrl import adc_ctrl_pkg::*; #(
	parameter int unsigned RESULT_W = RESULT_BITS,
	parameter int unsigned FSEL_SILENCE = FSEL_SILENCE_CYCLES,
	parameter int unsigned ISCK_HALF = ISCK_HALF_CYCLES
) (
	// clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// serial pins
	input wire logic i_cs_n,
	input wire logic i_sck,
	output logic o_sck,
	output logic o_sck_oe,
	output logic o_sck_pullup,
	output logic o_sdo,
	output logic o_sdo_oe,
	// frequency control pin
	input wire logic i_freq_select_input,
	// converter core
	input wire logic i_conv_done,
	input wire logic [RESULT_W-1:0] i_conv_result,
	output logic o_conv_start,
	output logic o_sleep,
	output logic o_ext_sysclk,
	output logic o_sysclk_tick,
	output logic o_null_60hz
);
	localparam int unsigned BW = $clog2(RESULT_W + 1);
	localparam int unsigned SW = $clog2(FSEL_SILENCE + 1);
	localparam logic [BW-1:0] BIT_LAST = BW'(RESULT_W - 1);
	localparam logic [SW-1:0] SIL_LAST = SW'(FSEL_SILENCE - 1);
	generate
		if (RESULT_W < 2 || FSEL_SILENCE < 2) begin : g_bad_param
			$error("adc_serial_readout_ctrl: RESULT_W and FSEL_SILENCE must be 2 or more");
		end
	endgenerate

	// =====================================================
	// pin synchronisers: change counts once stages two and three agree
	logic [2:0] pin_raw, s1_q, s2_q, s3_q, lvl_q, lvl_d;
	assign pin_raw = {i_freq_select_input, i_sck, i_cs_n};
	always_comb begin
		lvl_d = lvl_q;
		for (int i = 0; i < 3; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				lvl_d[i] = s3_q[i];
			end
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			s1_q <= PIN_RESET;
			s2_q <= PIN_RESET;
			s3_q <= PIN_RESET;
			lvl_q <= PIN_RESET;
		end else if (i_ce) begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	function automatic logic rose(input logic old_v, input logic new_v);
		rose = !old_v && new_v;
	endfunction

	// =====================================================
	// internal serial clock
	serial_clk_if sif ();
	sck_gen #(.HALF(ISCK_HALF)) u_sck_gen (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.sif(sif)
	);

	// =====================================================
	// control state
	phase_type phase_q, phase_d;
	logic [RESULT_W-1:0] shift_q, shift_d;
	logic [BW-1:0] bits_q, bits_d;
	logic [SW-1:0] sil_q, sil_d;
	logic init_q, started_q, started_d, int_mode_q, int_mode_d, ext_q, ext_d;
	logic start_d, sdo_d, sdo_oe_d, sleep_d, sck_oe_d, tick_d, null60_d;
	logic cs_rise, cs_fall, sck_rise, sck_fall, fsel_edge;

	always_comb begin
		cs_rise = rose(lvl_q[PIN_CS], lvl_d[PIN_CS]);
		cs_fall = rose(lvl_d[PIN_CS], lvl_q[PIN_CS]);
		fsel_edge = lvl_q[PIN_FSEL] ^ lvl_d[PIN_FSEL];
		sck_rise = int_mode_q ? sif.rise : rose(lvl_q[PIN_SCK], lvl_d[PIN_SCK]);
		sck_fall = int_mode_q ? sif.fall : rose(lvl_d[PIN_SCK], lvl_q[PIN_SCK]);
		sif.run = (phase_q == ST_DOUT) && !lvl_q[PIN_CS] && int_mode_q;
		phase_d = phase_q;
		shift_d = shift_q;
		bits_d = bits_q;
		started_d = started_q;
		start_d = !init_q;
		int_mode_d = int_mode_q;
		if (!init_q || cs_fall) begin
			// pin high (pulled up or left floating) selects the internal clock
			int_mode_d = lvl_q[PIN_SCK];
		end
		// a toggling frequency pin is taken as the external system clock
		sil_d = sil_q;
		ext_d = ext_q;
		if (fsel_edge) begin
			sil_d = '0;
			ext_d = 1'b1;
		end else if (sil_q == SIL_LAST) begin
			ext_d = 1'b0;
		end else begin
			sil_d = sil_q + SW'(1);
		end
		tick_d = ext_q && rose(lvl_q[PIN_FSEL], lvl_d[PIN_FSEL]);
		null60_d = !ext_d && !lvl_d[PIN_FSEL];
		case (phase_q)
			ST_CONV: begin
				if (i_conv_done) begin
					shift_d = i_conv_result;
					phase_d = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (!lvl_q[PIN_CS]) begin
					phase_d = ST_DOUT;
					started_d = 1'b0;
					bits_d = '0;
				end
			end
			ST_DOUT: begin
				if (cs_rise) begin
					if (started_q) begin
						phase_d = ST_CONV;
						start_d = 1'b1;
					end else begin
						phase_d = ST_SLEEP;
					end
				end else begin
					if (sck_fall && started_q) begin
						shift_d = {shift_q[RESULT_W-2:0], 1'b0};
					end
					if (sck_rise) begin
						started_d = 1'b1;
						bits_d = bits_q + BW'(1);
						if (bits_q == BIT_LAST) begin
							phase_d = ST_CONV;
							start_d = 1'b1;
						end
					end
				end
			end
			default: begin
				phase_d = ST_CONV;
				start_d = 1'b1;
			end
		endcase
		sdo_d = (phase_d == ST_DOUT) ? shift_d[RESULT_W-1] : (phase_d == ST_CONV);
		sdo_oe_d = !lvl_d[PIN_CS];
		sleep_d = (phase_d == ST_SLEEP) && lvl_d[PIN_CS];
		sck_oe_d = int_mode_d && (phase_d == ST_DOUT) && !lvl_d[PIN_CS];
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			phase_q <= ST_CONV;
			shift_q <= '0;
			bits_q <= '0;
			sil_q <= '0;
			init_q <= 1'b0;
			started_q <= 1'b0;
			int_mode_q <= 1'b1;
			ext_q <= 1'b0;
			o_conv_start <= 1'b0;
			o_sdo <= 1'b1;
			o_sdo_oe <= 1'b0;
			o_sleep <= 1'b0;
			o_sck_oe <= 1'b0;
			o_sck_pullup <= 1'b1;
			o_ext_sysclk <= 1'b0;
			o_sysclk_tick <= 1'b0;
			o_null_60hz <= 1'b0;
		end else if (i_ce) begin
			phase_q <= phase_d;
			shift_q <= shift_d;
			bits_q <= bits_d;
			sil_q <= sil_d;
			init_q <= 1'b1;
			started_q <= started_d;
			int_mode_q <= int_mode_d;
			ext_q <= ext_d;
			o_conv_start <= start_d;
			o_sdo <= sdo_d;
			o_sdo_oe <= sdo_oe_d;
			o_sleep <= sleep_d;
			o_sck_oe <= sck_oe_d;
			o_sck_pullup <= int_mode_d;
			o_ext_sysclk <= ext_d;
			o_sysclk_tick <= tick_d;
			o_null_60hz <= null60_d;
		end
	end

	// level flop inside the divider; high while idle
	assign o_sck = sif.level;
endmodule

// file: bench/adc_ctrl_monitor.sv
`timescale 1ns/1ps
module adc_ctrl_monitor (
	// watched ports
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_cs_n,
	input wire logic i_freq_select_input,
	input wire logic i_conv_done,
	input wire logic o_sck_oe,
	input wire logic o_sck_pullup,
	input wire logic o_sdo,
	input wire logic o_sdo_oe,
	input wire logic o_conv_start,
	input wire logic o_sleep,
	input wire logic o_ext_sysclk,
	input wire logic o_sysclk_tick,
	input wire logic o_null_60hz
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);
	// =====================================
	// six samples cover the pin synchroniser
	sdo_hiz_a: assert property (i_cs_n [*6] |-> !o_sdo_oe)
		else $error("sdo driven");
	sdo_en_a: assert property (!i_cs_n [*6] |-> o_sdo_oe)
		else $error("sdo not driven");
	sleep_cs_a: assert property (o_sleep |-> !o_sdo_oe)
		else $error("sleep with cs low");
	start_pulse_a: assert property (o_conv_start |=> !o_conv_start)
		else $error("start too long");
	start_busy_a: assert property (o_conv_start |=> o_sdo)
		else $error("no busy status");
	sleep_cause_a: assert property ($rose(o_sleep) |-> $past(i_conv_done) || $past(o_sdo_oe))
		else $error("sleep without cause");
	drive_sel_a: assert property (o_sck_oe |-> o_sdo_oe && o_sck_pullup)
		else $error("sck driven wrongly");
	null_50_a: assert property ((i_freq_select_input && !o_ext_sysclk) [*8] |-> !o_null_60hz)
		else $error("wrong null");
	tick_one_a: assert property (o_sysclk_tick |=> !o_sysclk_tick)
		else $error("tick too long");
	cover property ($fell(o_sleep));
	cover property (o_sck_oe);
	cover property (o_ext_sysclk);
endmodule

// file: bench/host_master.sv
`timescale 1ns/1ps
module host_master (
	// clock and pins
	input wire logic i_sys_clk,
	input wire logic i_sck,
	input wire logic i_sdo,
	output logic o_cs_n,
	output logic o_sck,
	output logic o_sck_oe
);
	initial begin
		o_cs_n = 1;
		o_sck = 0;
		o_sck_oe = 0;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge i_sys_clk);
		#2;
	endtask
	// =====================================
	// frame leaves cs low so the caller picks the ending
	task automatic frame(input int n, input bit ext, output logic [23:0] q);
		q = 0;
		// the pin level across the select edge picks the clock mode
		o_sck = !ext;
		o_sck_oe = 1;
		tk(4);
		o_cs_n = 0;
		tk(4);
		// internal mode: let go before the device starts to drive the pin
		o_sck_oe = ext;
		tk(4);
		for (int i = 0; i < n; i++) begin
			if (ext) begin
				o_sck = 0;
				tk(8);
				q = {q[22:0], i_sdo};
				o_sck = 1;
				tk(i < n - 1 ? 8 : 1);
			end else begin
				@(posedge i_sck);
				// sample clear of the edge that launches the clock
				tk(0);
				q = {q[22:0], i_sdo};
			end
		end
	endtask
endmodule

// file: bench/adc_serial_readout_ctrl_test.sv
`timescale 1ns/1ps
module adc_serial_readout_ctrl_test;
	logic i_sys_clk = 0;
	logic i_rst_n = 0;
	logic fsel = 1;
	logic ce = 1;
	logic done = 0;
	logic [23:0] res = 24'h0;
	logic [23:0] q;
	logic o_sck, o_sck_oe, o_sck_pullup, o_sdo, o_sdo_oe, o_conv_start, o_sleep;
	logic o_ext_sysclk, o_sysclk_tick, o_null_60hz, cs_n, h_sck, h_oe;
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;
	int ticks = 0;
	// released pin falls to the pull-up level, or low without it
	wire sck_pin = o_sck_oe ? o_sck : h_oe ? h_sck : o_sck_pullup;
	wire sdo_pin = o_sdo_oe ? o_sdo : 1'bz;
	adc_serial_readout_ctrl #(.FSEL_SILENCE(50), .ISCK_HALF(3)) dut_u (
		.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_cs_n(cs_n),
		.i_sck(sck_pin), .o_sck(o_sck), .o_sck_oe(o_sck_oe), .o_sck_pullup(o_sck_pullup),
		.o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .i_freq_select_input(fsel), .i_conv_done(done),
		.i_conv_result(res), .o_conv_start(o_conv_start), .o_sleep(o_sleep),
		.o_ext_sysclk(o_ext_sysclk), .o_sysclk_tick(o_sysclk_tick), .o_null_60hz(o_null_60hz));
	host_master host_u (.i_sys_clk(i_sys_clk), .i_sck(sck_pin), .i_sdo(sdo_pin),
		.o_cs_n(cs_n), .o_sck(h_sck), .o_sck_oe(h_oe));
	initial forever #20 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) begin
		ticks <= ticks + (o_sysclk_tick === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic conclude();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// =====================================
	// ends the frame, waits for the new conversion when ws is set, and completes it
	task automatic conv(input bit ws, input logic [23:0] r);
		int i;
		i = 0;
		host_u.o_cs_n = 1;
		host_u.o_sck_oe = 0;
		while (ws && o_conv_start !== 1'b1 && i < 40) begin
			host_u.tk(1);
			i++;
		end
		if (ws) chk("conv start", 1, o_conv_start);
		host_u.tk(5);
		res = r;
		done = 1;
		host_u.tk(1);
		done = 0;
		host_u.tk(1);
		chk("sleep", 1, o_sleep);
		chk("sdo enable", 0, o_sdo_oe);
	endtask
	task automatic t_status();
		chk("conv start", 1, o_conv_start);
		host_u.o_cs_n = 0;
		host_u.tk(8);
		chk("sdo enable", 1, o_sdo_oe);
		chk("busy status", 1, o_sdo);
		conv(0, 24'h5A0F3C);
	endtask
	task automatic t_reads();
		host_u.frame(24, 1, q);
		chk("ext data", 24'h5A0F3C, q);
		chk("ext pullup", 0, o_sck_pullup);
		conv(1, 24'hC3A50F);
		host_u.frame(24, 0, q);
		chk("int data", 24'hC3A50F, q);
		chk("pullup", 1, o_sck_pullup);
		conv(1, 24'h96C3A5);
	endtask
	task automatic t_aborts();
		host_u.frame(0, 1, q);
		host_u.o_cs_n = 1;
		host_u.tk(8);
		chk("early sleep", 1, o_sleep);
		host_u.frame(5, 1, q);
		chk("part data", 24'h12, q);
		conv(1, 24'h0F1E2D);
	endtask
	task automatic t_freq();
		host_u.tk(12);
		chk("null 50", 0, o_null_60hz);
		fsel = 0;
		// a lone edge looks like an external clock until the silence timeout
		host_u.tk(70);
		chk("null 60", 1, o_null_60hz);
		repeat (40) begin
			fsel = ~fsel;
			host_u.tk(4);
		end
		chk("ext clock", 1, o_ext_sysclk);
		// the first rise only arms the detector, so one tick fewer than rises
		chk("ticks", 24'h13, ticks[23:0]);
	endtask
	task automatic t_freeze();
		ce = 0;
		host_u.tk(100);
		chk("frozen ext", 1, o_ext_sysclk);
		ce = 1;
		host_u.tk(70);
		chk("ext timeout", 0, o_ext_sysclk);
		chk("null 60 again", 1, o_null_60hz);
	endtask
	initial begin
		host_u.tk(4);
		i_rst_n = 1;
		host_u.tk(1);
		t_status();
		t_reads();
		t_aborts();
		t_freq();
		t_freeze();
		conclude();
	end
endmodule
bind adc_serial_readout_ctrl adc_ctrl_monitor mon_u (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
	.i_cs_n(i_cs_n), .i_freq_select_input(i_freq_select_input), .i_conv_done(i_conv_done),
	.o_sck_oe(o_sck_oe), .o_sck_pullup(o_sck_pullup), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
	.o_conv_start(o_conv_start), .o_sleep(o_sleep), .o_ext_sysclk(o_ext_sysclk),
	.o_sysclk_tick(o_sysclk_tick), .o_null_60hz(o_null_60hz));
